// >>> core/plwt_pkg.sv
package plwt_pkg;

  // core clock and the pixel-rate ceiling, both in MHz
  localparam int CORE_CLK_MHZ = 250;
  localparam int PIX_MAX_MHZ = 25;
  // cycles per pixel: round up so the pixel rate never exceeds the ceiling
  localparam int PIX_DIV = (CORE_CLK_MHZ + PIX_MAX_MHZ - 1) / PIX_MAX_MHZ;
  localparam int PIX_CNT_W = 4;
  localparam logic [PIX_CNT_W-1:0] PIX_CNT_LAST = PIX_CNT_W'(PIX_DIV - 1);
  localparam logic [PIX_CNT_W-1:0] PIX_CNT_RST = 4'h0;

  // pixel bus width and reset values of the pins
  localparam int PIX_W = 8;
  localparam int TAG_W = 2;
  localparam logic [PIX_W-1:0] PIX_RST = 8'h00;
  localparam logic SYNC_RST = 1'b0;
  localparam logic BLANK_RST = 1'b1;

  // bit positions of the tag on the shared sync pins
  localparam int TAG_HSYNC_BIT = 0;
  localparam int TAG_VSYNC_BIT = 1;

  // live pixel bits per depth; the rest come from the pad value
  localparam logic [PIX_W-1:0] MASK_1BPP = 8'h01;
  localparam logic [PIX_W-1:0] MASK_2BPP = 8'h03;
  localparam logic [PIX_W-1:0] MASK_4BPP = 8'h0F;
  localparam logic [PIX_W-1:0] MASK_8BPP = 8'hFF;

  typedef enum logic [1:0] {
    PLWT_BPP1,
    PLWT_BPP2,
    PLWT_BPP4,
    PLWT_BPP8
  } plwt_bpp_e;

  // one pixel slot as scanned out by the display engine
  typedef struct packed {
    logic hblank;
    logic vblank;
    logic hsync;
    logic vsync;
    logic cursor_hit;
    logic [TAG_W-1:0] window_tag;
    logic [PIX_W-1:0] pixel;
  } plwt_scan_s;

  // software-programmed configuration
  typedef struct packed {
    logic [PIX_W-1:0] default_value;
    logic [PIX_W-1:0] pad_value;
    plwt_bpp_e bpp;
    logic tag_mux_en;
    logic [TAG_W-1:0] cursor_tag_override;
  } plwt_cfg_s;

endpackage

// >>> core/plwt_rate_div.sv
`timescale 1ns/100ps

module plwt_rate_div (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic pix_tick
);

  logic [plwt_pkg::PIX_CNT_W-1:0] cnt_q;
  logic [plwt_pkg::PIX_CNT_W-1:0] cnt_d;
  logic wrap;

  // wrap at the last count so one slot spans a whole pixel period
  assign wrap = (cnt_q == plwt_pkg::PIX_CNT_LAST);
  assign cnt_d = wrap ? plwt_pkg::PIX_CNT_RST : cnt_q + 1'b1;

  // tick is registered so the main block sees a clean one-cycle strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= plwt_pkg::PIX_CNT_RST;
      pix_tick <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      pix_tick <= wrap;
    end
  end

  // no two ticks closer than nine cycles, one short of the pixel period
  a_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && pix_tick) |=> !pix_tick [*8])
    else $error("pixel ticks closer than the pixel period");

endmodule

// >>> core/plwt_top.sv
`timescale 1ns/100ps

// Overview of operation
// - blanking drives programmed default onto pixel bus
// - two window tag bits from tile descriptor
// - tag pins follow the window being scanned
// - cursor region substitutes the cursor tag value
// - muxed tags on sync pins while visible
// - config bit selects tags onto sync pins
// - mux disabled holds sync pins low visibly
// - pixel rate never above 25 MHz
// - unused low-depth pixel bits take pad value

module plwt_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire plwt_pkg::plwt_scan_s scan,
  input wire plwt_pkg::plwt_cfg_s cfg,
  output logic [plwt_pkg::PIX_W-1:0] pixel_out_bus,
  output logic hsync_pin,
  output logic vsync_pin,
  output logic blank_pin,
  output logic [plwt_pkg::TAG_W-1:0] window_tag,
  output logic pix_strobe
);

  logic pix_tick;
  logic adv;
  logic blank;
  logic [plwt_pkg::PIX_W-1:0] depth_mask;
  logic [plwt_pkg::PIX_W-1:0] padded;
  logic [plwt_pkg::PIX_W-1:0] pixel_d;
  logic [plwt_pkg::TAG_W-1:0] tag_sel;
  logic hsync_d;
  logic vsync_d;

  // pixel slot divider keeps output updates at or below the pixel ceiling
  plwt_rate_div u_rate_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pix_tick(pix_tick)
  );

  assign adv = clk_en & pix_tick;
  assign blank = scan.hblank | scan.vblank;

  // live bit mask from the current window depth
  assign depth_mask = (cfg.bpp == plwt_pkg::PLWT_BPP1) ? plwt_pkg::MASK_1BPP :
                      (cfg.bpp == plwt_pkg::PLWT_BPP2) ? plwt_pkg::MASK_2BPP :
                      (cfg.bpp == plwt_pkg::PLWT_BPP4) ? plwt_pkg::MASK_4BPP :
                      plwt_pkg::MASK_8BPP;

  // per-bit merge of live pixel data with the pad levels
  for (genvar b = 0; b < plwt_pkg::PIX_W; b++) begin : g_pad
    assign padded[b] = depth_mask[b] ? scan.pixel[b] : cfg.pad_value[b];
  end

  // blanking presents the palette write address instead of pixel data
  assign pixel_d = blank ? cfg.default_value : padded;

  // cursor wins over the window's own tag
  assign tag_sel = scan.cursor_hit ? cfg.cursor_tag_override : scan.window_tag;

  // visible time: tags or low; blanking: true sync levels
  assign hsync_d = blank ? scan.hsync :
                   (cfg.tag_mux_en & tag_sel[plwt_pkg::TAG_HSYNC_BIT]);
  assign vsync_d = blank ? scan.vsync :
                   (cfg.tag_mux_en & tag_sel[plwt_pkg::TAG_VSYNC_BIT]);

  // all pins but pix_strobe update together once per pixel slot, so no skew between them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pixel_out_bus <= plwt_pkg::PIX_RST;
      hsync_pin <= plwt_pkg::SYNC_RST;
      vsync_pin <= plwt_pkg::SYNC_RST;
      blank_pin <= plwt_pkg::BLANK_RST;
      window_tag <= '0;
      pix_strobe <= 1'b0;
    end else if (clk_en) begin
      pix_strobe <= pix_tick;
      if (pix_tick) begin
        pixel_out_bus <= pixel_d;
        hsync_pin <= hsync_d;
        vsync_pin <= vsync_d;
        blank_pin <= blank;
        window_tag <= tag_sel;
      end
    end
  end

  // checks look one edge after a slot loads, when the new pin values are sampled
  // reset and freeze checks cover the cases that no pixel slot exercises

  // pins rest at their reset levels while reset is held
  a_rst_pins: assert property (@(posedge core_clk)
    !rst_n |=>
      (pixel_out_bus == plwt_pkg::PIX_RST) && (blank_pin == plwt_pkg::BLANK_RST)
      && (hsync_pin == plwt_pkg::SYNC_RST) && (vsync_pin == plwt_pkg::SYNC_RST))
    else $error("pins not at rest during reset");

  // no slot marker and no tag while in reset
  a_rst_strobe: assert property (@(posedge core_clk)
    !rst_n |=>
      !pix_strobe && (window_tag == 2'h0))
    else $error("strobe or tag active during reset");

  // low enable freezes the pixel bus, tag and blank pins
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=>
      $stable(pixel_out_bus) && $stable(window_tag) && $stable(blank_pin))
    else $error("pins moved while frozen");

  // a frozen strobe must not be taken as a second slot
  a_freeze_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=>
      $stable(pix_strobe) && $stable(hsync_pin) && $stable(vsync_pin))
    else $error("strobe or sync moved while frozen");

  // strobe marks exactly the cycle in which a slot has loaded
  a_strobe_update: assert property (@(posedge core_clk) disable iff (!rst_n)
    adv |=>
      pix_strobe)
    else $error("strobe missing after slot load");

  // strobe is a single enabled cycle wide
  a_strobe_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && pix_strobe) |=>
      !pix_strobe)
    else $error("strobe wider than one cycle");

  // blank pin high for a blanking slot
  a_blank_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && blank) |=>
      blank_pin)
    else $error("blank pin low in blanking");

  // blank pin low for a visible slot, so far-side demux sees tags
  a_blank_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank) |=>
      !blank_pin)
    else $error("blank pin high in visible time");

  // two live bits at 2 bpp, the rest padded
  a_pad_two_bpp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.bpp == plwt_pkg::PLWT_BPP2) |=>
      (pixel_out_bus[7:2] == $past(cfg.pad_value[7:2]))
      && (pixel_out_bus[1:0] == $past(scan.pixel[1:0])))
    else $error("2-bpp pad bits wrong");

  // four live bits at 4 bpp, the rest padded
  a_pad_four_bpp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.bpp == plwt_pkg::PLWT_BPP4) |=>
      (pixel_out_bus[7:4] == $past(cfg.pad_value[7:4]))
      && (pixel_out_bus[3:0] == $past(scan.pixel[3:0])))
    else $error("4-bpp pad bits wrong");

  // full depth passes every pixel bit, no pad
  a_full_depth: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.bpp == plwt_pkg::PLWT_BPP8) |=>
      pixel_out_bus == $past(scan.pixel))
    else $error("8-bpp pixel not passed through");

  // pad levels never leak into the palette address during blanking at 1 bpp
  a_default_over_pad: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && blank && cfg.bpp == plwt_pkg::PLWT_BPP1) |=>
      pixel_out_bus == $past(cfg.default_value))
    else $error("pad applied to blanking address");

  // cursor value reaches the shared sync pins, not only the tag pins
  a_cursor_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.tag_mux_en && scan.cursor_hit) |=>
      {vsync_pin, hsync_pin} == $past(cfg.cursor_tag_override))
    else $error("cursor tag missing on sync pins");

  // with muxing off the cursor must not leak onto the sync pins
  a_mux_cursor_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && !cfg.tag_mux_en && scan.cursor_hit) |=>
      !hsync_pin && !vsync_pin)
    else $error("cursor tag leaked with muxing off");

  // palette address shown for any blanking slot
  a_default_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && blank) |=> (pixel_out_bus == $past(cfg.default_value)) && blank_pin)
    else $error("default value not shown during blanking");

  a_pad_fill: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.bpp == plwt_pkg::PLWT_BPP1) |=>
      (pixel_out_bus[7:1] == $past(cfg.pad_value[7:1]))
      && (pixel_out_bus[0] == $past(scan.pixel[0])))
    else $error("1-bpp pad bits wrong");

  a_window_tag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !scan.cursor_hit) |=> window_tag == $past(scan.window_tag))
    else $error("tag does not follow scanned window");

  a_cursor_tag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && scan.cursor_hit) |=> window_tag == $past(cfg.cursor_tag_override))
    else $error("cursor tag not substituted");

  a_tag_on_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && cfg.tag_mux_en) |=>
      ({vsync_pin, hsync_pin} == window_tag) && !blank_pin)
    else $error("tag not on sync pins while visible");

  a_sync_low_vis: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && !blank && !cfg.tag_mux_en) |=> !hsync_pin && !vsync_pin)
    else $error("sync pins not low in visible time");

  a_real_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adv && blank) |=> hsync_pin == $past(scan.hsync) && vsync_pin == $past(scan.vsync))
    else $error("real sync not shown during blanking");

  a_pins_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !adv |=> $stable(pixel_out_bus) && $stable(hsync_pin) && $stable(window_tag)
      && $stable(vsync_pin) && $stable(blank_pin))
    else $error("pins changed between pixel slots");

endmodule

// >>> testbench/plwt_palette_model.sv
`timescale 1ns/100ps

// palette ram behind its load latch; write lands on the next sync rise in blanking
module plwt_palette_model (
  input wire logic core_clk,
  input wire logic [7:0] pixel_out_bus,
  input wire logic hsync_pin,
  input wire logic blank_pin,
  input wire logic latch_we,
  input wire logic [15:0] latch_data,
  input wire logic [2:0] latch_sel,
  input wire logic [1:0] area_sel,
  output logic loading
);
  logic [15:0] ram_q [1024];
  logic [15:0] latch_q;
  logic [2:0] sel_q;
  logic [15:0] merged;
  logic [9:0] idx;
  logic sync_q;
  initial begin
    loading = 1'b0;
    sync_q = 1'b0;
  end
  // host drives the area bits itself; the tag pins are not used to form the index
  assign idx = {area_sel, pixel_out_bus};
  // lanes red 11:8, green 7:4, blue 3:0; no select writes the whole word
  always_comb begin
    merged = ram_q[idx];
    if (sel_q == 3'b000) merged = latch_q;
    if (sel_q[2]) merged[11:8] = latch_q[3:0];
    if (sel_q[1]) merged[7:4] = latch_q[3:0];
    if (sel_q[0]) merged[3:0] = latch_q[3:0];
  end
  // edge detect on sync so one sync interval gives exactly one write
  always @(posedge core_clk) begin
    sync_q <= hsync_pin;
    if (latch_we) begin
      latch_q <= latch_data;
      sel_q <= latch_sel;
      loading <= 1'b1;
    end else if (loading && blank_pin && hsync_pin && !sync_q) begin
      ram_q[idx] <= merged;
      loading <= 1'b0;
    end
  end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  logic core_clk, rst_n, clk_en, latch_we, loading, pix_strobe, hsync_pin, vsync_pin, blank_pin;
  logic [7:0] pixel_out_bus;
  logic [1:0] window_tag;
  logic [15:0] latch_data;
  logic [2:0] latch_sel;
  logic [1:0] area_sel;
  plwt_pkg::plwt_scan_s scan;
  plwt_pkg::plwt_cfg_s cfg;
  int num_errors = 0;
  int n_compared = 0;
  wire [12:0] got = {pixel_out_bus, hsync_pin, vsync_pin, blank_pin, window_tag};
  // far-side demux: blank separates tags from sync on the shared pins
  wire [1:0] demux_tag = blank_pin ? 2'h0 : {vsync_pin, hsync_pin};
  plwt_top plwt_top_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .scan(scan),
    .cfg(cfg), .pixel_out_bus(pixel_out_bus), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin),
    .blank_pin(blank_pin), .window_tag(window_tag), .pix_strobe(pix_strobe));
  plwt_palette_model plwt_palette_model_i (.core_clk(core_clk), .pixel_out_bus(pixel_out_bus),
    .hsync_pin(hsync_pin), .blank_pin(blank_pin), .latch_we(latch_we),
    .latch_data(latch_data), .latch_sel(latch_sel), .area_sel(area_sel), .loading(loading));
  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait for the cycle in which a new slot shows
  task automatic wait_strobe;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      #1;
      if (pix_strobe === 1'b1) return;
    end
    num_errors++;
    print_verdict();
  endtask
  // drive just after a slot loads so inputs stand a whole slot
  task automatic slot(input plwt_pkg::plwt_scan_s s, input plwt_pkg::plwt_cfg_s c);
    wait_strobe();
    @(posedge core_clk);
    scan <= s;
    cfg <= c;
    wait_strobe();
  endtask
  function automatic logic [12:0] expect_of(plwt_pkg::plwt_scan_s s, plwt_pkg::plwt_cfg_s c);
    logic [7:0] m;
    logic [1:0] t;
    m = c.bpp == plwt_pkg::PLWT_BPP1 ? 8'h01 : c.bpp == plwt_pkg::PLWT_BPP2 ? 8'h03 :
        c.bpp == plwt_pkg::PLWT_BPP4 ? 8'h0F : 8'hFF;
    t = s.cursor_hit ? c.cursor_tag_override : s.window_tag;
    if (s.hblank || s.vblank) return {c.default_value, s.hsync, s.vsync, 1'b1, t};
    return {(s.pixel & m) | (c.pad_value & ~m), c.tag_mux_en & t[0], c.tag_mux_en & t[1], 1'b0, t};
  endfunction
  task automatic t_scan;
    plwt_pkg::plwt_scan_s s;
    plwt_pkg::plwt_cfg_s c;
    s = '0;
    c = '0;
    s.pixel = 8'hC6;
    s.window_tag = 2'h2;
    c.pad_value = 8'h5A;
    c.default_value = 8'hA5;
    c.cursor_tag_override = 2'h1;
    for (int i = 0; i < 4; i++) begin
      c.bpp = plwt_pkg::plwt_bpp_e'(i);
      c.tag_mux_en = i[0];
      s.cursor_hit = i[1];
      slot(s, c);
      chk(got, expect_of(s, c));
      chk(demux_tag, c.tag_mux_en ? (s.cursor_hit ? c.cursor_tag_override : s.window_tag) : 2'h0);
      s.hblank = i[0];
      s.vblank = ~i[0];
      s.hsync = i[1];
      s.vsync = ~i[1];
      slot(s, c);
      chk(got, expect_of(s, c));
      s.hblank = 1'b0;
      s.vblank = 1'b0;
    end
    $display("scan test done");
  endtask
  // slot spacing sets the pixel rate
  task automatic t_rate;
    int n;
    n = 0;
    wait_strobe();
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pix_strobe !== 1'b1 && n < 30);
    chk(n, 10);
    $display("rate test done");
  endtask
  // low enable stretches a slot; a mid-run reset puts the pins back at rest
  task automatic t_freeze;
    logic [12:0] held;
    int n;
    wait_strobe();
    held = got;
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    chk(got, held);
    chk(pix_strobe, 1'b0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pix_strobe !== 1'b1 && n < 30);
    chk(n, 9);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(got, 13'h0004);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pix_strobe !== 1'b1 && n < 30);
    chk(n, 11);
    $display("freeze test done");
  endtask
  // one host load: latch it, then an hsync rise in blanking writes it
  task automatic pal_load(input logic [15:0] d, input logic [2:0] sel, input logic [1:0] area,
    input plwt_pkg::plwt_scan_s s, input plwt_pkg::plwt_cfg_s c);
    s.hsync = 1'b0;
    slot(s, c);
    @(posedge core_clk);
    latch_we <= 1'b1;
    latch_data <= d;
    latch_sel <= sel;
    area_sel <= area;
    @(posedge core_clk);
    latch_we <= 1'b0;
    #1;
    chk(loading, 1'b1);
    s.hsync = 1'b1;
    slot(s, c);
    for (int i = 0; i < 40 && loading !== 1'b0; i++) @(posedge core_clk);
    chk(loading, 1'b0);
  endtask
  task automatic t_palette;
    plwt_pkg::plwt_scan_s s;
    plwt_pkg::plwt_cfg_s c;
    s = '0;
    c = '0;
    s.hblank = 1'b1;
    c.default_value = 8'h3C;
    pal_load(16'hBEEF, 3'b000, 2'h2, s, c);
    chk(plwt_palette_model_i.ram_q[10'h23C], 16'hBEEF);
    pal_load(16'h0007, 3'b101, 2'h2, s, c);
    chk(plwt_palette_model_i.ram_q[10'h23C], 16'hB7E7);
    $display("palette test done");
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    scan = '0;
    cfg = '0;
    latch_we = 1'b0;
    latch_data = 16'h0000;
    latch_sel = 3'h0;
    area_sel = 2'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(got, 13'h0004);
    t_scan();
    t_rate();
    t_freeze();
    t_palette();
    print_verdict();
  end
endmodule
